// [verilog/bkpwm_pkg.sv]
// package: register map, field layout, reset values and encodings of the keying/pwm modulator
package bkpwm_pkg;
    // register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_KEY_INC   = 8'h04;
    localparam logic [7:0] REG_MOD_INC   = 8'h08;
    localparam logic [7:0] REG_CAR_INC   = 8'h0C;
    localparam logic [7:0] REG_HOP_INC   = 8'h10;
    localparam logic [7:0] REG_WIDTH     = 8'h14;
    localparam logic [7:0] REG_WDEV      = 8'h18;
    localparam logic [7:0] REG_STATUS    = 8'h1C;
    // control field positions
    localparam int CTRL_EN_POS    = 0;
    localparam int CTRL_TYPE_LSB  = 1;
    localparam int CTRL_SRC_LSB   = 4;
    localparam int CTRL_SHAPE_LSB = 6;
    localparam int CTRL_POL_POS   = 8;
    localparam int CTRL_PULSE_POS = 9;
    // reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] INC_RST     = 32'h0000_0000;
    localparam logic [15:0] WIDTH_RST   = 16'h8000;
    localparam logic [15:0] WDEV_RST    = 16'h0000;
    // modulation types
    localparam logic [2:0] TYPE_OFF = 3'h0;
    localparam logic [2:0] TYPE_PWM = 3'h1;
    localparam logic [2:0] TYPE_ASK = 3'h2;
    localparam logic [2:0] TYPE_FSK = 3'h3;
    localparam logic [2:0] TYPE_PSK = 3'h4;
    // modulation sources
    localparam logic [1:0] SRC_INT  = 2'h0;
    localparam logic [1:0] SRC_EXT  = 2'h1;
    localparam logic [1:0] SRC_CHAN = 2'h2;
    // internal shapes
    localparam logic [1:0] SHAPE_SQUARE = 2'h0;
    localparam logic [1:0] SHAPE_TRI    = 2'h1;
    localparam logic [1:0] SHAPE_SAW    = 2'h2;
    // phase offset of half a turn on the 32-bit accumulator
    localparam logic [31:0] PHASE_HALF = 32'h8000_0000;
    // internal keying clock runs at twice the programmed keying rate
    localparam int KEY_RATE_MUL = 2;
endpackage

// [verilog/bkpwm_sync.sv]
// three-stage input synchroniser; output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module bkpwm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] s1;   // metastability catcher, read only by s2
    logic [W-1:0] s2;   // second stage
    logic [W-1:0] s3;   // third stage

    // shift chain
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // accept a new value per bit only once two stages agree, filtering single glitches
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                    dout[i] <= 1'b0;
                else if (s2[i] == s3[i])
                    dout[i] <= s3[i];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [verilog/bkpwm_top.sv]
// keying and pulse width modulation control for one carrier channel
// Summary of operation
// RULE_01 - pwm only allowed with pulse carrier
// RULE_02 - width swings about nominal by full deviation
// RULE_03 - external full swing gives exact deviation
// RULE_04 - ask: carrier on for 1, off for 0
// RULE_05 - internal keying clock at twice keying rate
// RULE_06 - external keying bit follows trigger level
// RULE_07 - fsk: hop frequency for 1, carrier for 0
// RULE_08 - psk phase per transition and polarity
// RULE_09 - channel source routed internally, no cable
// RULE_10 - channel source only while that channel enabled
// RULE_11 - external input full swing is full depth
// RULE_12 - external source ignores own frequency, shape, depth
// RULE_13 - internal uses settings; others use source signal
// RULE_14 - switch only at keying bit boundaries
`timescale 1ns/1ps
`default_nettype none
module bkpwm_top #(
    parameter int MW = 16              // modulating sample width, signed
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [7:0]    addr,          // register byte address
    input  wire logic [31:0]   wdata,         // write data
    input  wire logic          wr,            // write strobe
    input  wire logic          rd,            // read strobe
    output var  logic [31:0]   rdata,         // read data, cycle after rd
    input  wire logic          ext_trig,      // external trigger pin, keying level
    input  wire logic [MW-1:0] ext_mod,       // external modulation sample, full scale = full swing
    input  wire logic [MW-1:0] modulating_channel_wave,  // other channel's waveform
    input  wire logic          modulating_channel_en,    // other channel output enabled
    output var  logic [31:0]   carrier_channel_inc,      // phase increment to carrier dds
    output var  logic [31:0]   carrier_channel_phase,    // phase offset to carrier dds
    output var  logic          carrier_channel_on,       // amplitude gate of carrier
    output var  logic [15:0]   carrier_channel_width,    // positive pulse width, fraction of period
    output var  logic          pwm_refused               // pwm requested on non-pulse carrier
);
    // software registers
    logic [31:0] ctrl;       // enable, type, source, shape, polarity, pulse-carrier flag
    logic [31:0] key_inc;    // keying rate phase increment
    logic [31:0] mod_inc;    // internal modulating frequency increment
    logic [31:0] car_inc;    // carrier frequency increment (f0)
    logic [31:0] hop_inc;    // hop frequency increment (f1)
    logic [15:0] width;      // unmodulated pulse width
    logic [15:0] wdev;       // pulse width deviation

    // decoded fields
    logic        en;
    logic [2:0]  mtype;
    logic [1:0]  src;
    logic [1:0]  shape;
    logic        pol_inv;
    logic        is_pulse;
    assign en       = ctrl[bkpwm_pkg::CTRL_EN_POS];
    assign mtype    = ctrl[bkpwm_pkg::CTRL_TYPE_LSB +: 3];
    assign src      = ctrl[bkpwm_pkg::CTRL_SRC_LSB +: 2];
    assign shape    = ctrl[bkpwm_pkg::CTRL_SHAPE_LSB +: 2];
    assign pol_inv  = ctrl[bkpwm_pkg::CTRL_POL_POS];
    assign is_pulse = ctrl[bkpwm_pkg::CTRL_PULSE_POS];

    // synchronised pin
    logic trig_s;
    bkpwm_sync #(.W(1)) u_trig_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (ext_trig),
        .dout (trig_s)
    );

    // register writes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl    <= bkpwm_pkg::CTRL_RST;
            key_inc <= bkpwm_pkg::INC_RST;
            mod_inc <= bkpwm_pkg::INC_RST;
            car_inc <= bkpwm_pkg::INC_RST;
            hop_inc <= bkpwm_pkg::INC_RST;
            width   <= bkpwm_pkg::WIDTH_RST;
            wdev    <= bkpwm_pkg::WDEV_RST;
        end
        else if (wr)
        begin
            case (addr)
                bkpwm_pkg::REG_CTRL:    ctrl    <= {22'h000000, wdata[9:0]};
                bkpwm_pkg::REG_KEY_INC: key_inc <= wdata;
                bkpwm_pkg::REG_MOD_INC: mod_inc <= wdata;
                bkpwm_pkg::REG_CAR_INC: car_inc <= wdata;
                bkpwm_pkg::REG_HOP_INC: hop_inc <= wdata;
                bkpwm_pkg::REG_WIDTH:   width   <= wdata[15:0];
                bkpwm_pkg::REG_WDEV:    wdev    <= wdata[15:0];
                default:                ;   // unmapped writes ignored
            endcase
        end
    end

    // status word shows live block state
    logic        key_bit;
    logic        pwm_ok;
    logic [31:0] status;
    assign status = {26'h0000000, modulating_channel_en, trig_s, pwm_ok,
                     carrier_channel_on, key_bit, en};

    // register reads, data valid in the following cycle only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= 32'h0000_0000;
        else if (rd)
        begin
            case (addr)
                bkpwm_pkg::REG_CTRL:    rdata <= ctrl;
                bkpwm_pkg::REG_KEY_INC: rdata <= key_inc;
                bkpwm_pkg::REG_MOD_INC: rdata <= mod_inc;
                bkpwm_pkg::REG_CAR_INC: rdata <= car_inc;
                bkpwm_pkg::REG_HOP_INC: rdata <= hop_inc;
                bkpwm_pkg::REG_WIDTH:   rdata <= {16'h0000, width};
                bkpwm_pkg::REG_WDEV:    rdata <= {16'h0000, wdev};
                bkpwm_pkg::REG_STATUS:  rdata <= status;
                default:                rdata <= 32'h0000_0000;  // unmapped reads zero
            endcase
        end
        else
            rdata <= 32'h0000_0000;
    end

    // internal keying clock: accumulator at twice the keying rate, toggles the bit on wrap
    logic [31:0] key_acc;
    logic [32:0] key_sum;
    logic        key_wrap;
    assign key_sum  = {1'b0, key_acc} + {1'b0, key_inc[30:0], 1'b0};   // RULE_05
    assign key_wrap = key_sum[32];
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            key_acc <= 32'h0000_0000;
        else if (en && src == bkpwm_pkg::SRC_INT)
            key_acc <= key_sum[31:0];
        else
            key_acc <= 32'h0000_0000;
    end

    // raw keying bit per source; channel source only while it is enabled
    logic int_bit;
    logic raw_bit;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            int_bit <= 1'b0;
        else if (!en || src != bkpwm_pkg::SRC_INT)
            int_bit <= 1'b0;
        else if (key_wrap)
            int_bit <= ~int_bit;   // RULE_05
    end
    always_comb
    begin
        case (src)
            bkpwm_pkg::SRC_INT:  raw_bit = int_bit;
            bkpwm_pkg::SRC_EXT:  raw_bit = trig_s;   // RULE_06
            bkpwm_pkg::SRC_CHAN: raw_bit = modulating_channel_en
                                           & ~modulating_channel_wave[MW-1];   // RULE_09 RULE_10
            default:             raw_bit = 1'b0;
        endcase
    end

    // keying bit register: every ask, fsk and psk carrier change follows this one edge; the pwm width does not
    logic key_prev;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            key_bit  <= 1'b0;
            key_prev <= 1'b0;
        end
        else
        begin
            key_bit  <= raw_bit;   // RULE_14
            key_prev <= key_bit;
        end
    end

    // internal modulating waveform from its own phase accumulator
    logic [31:0]        mod_acc;
    logic signed [MW-1:0] int_wave;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mod_acc <= 32'h0000_0000;
        else
            mod_acc <= mod_acc + mod_inc;   // RULE_13
    end
    always_comb
    begin
        case (shape)
            bkpwm_pkg::SHAPE_SQUARE: int_wave = mod_acc[31] ? {1'b1, {(MW-1){1'b0}}}
                                                            : {1'b0, {(MW-1){1'b1}}};
            bkpwm_pkg::SHAPE_TRI:    int_wave = (mod_acc[31] ? ~mod_acc[30 -: MW]
                                                             : mod_acc[30 -: MW])
                                                ^ {1'b1, {(MW-1){1'b0}}};
            bkpwm_pkg::SHAPE_SAW:    int_wave = mod_acc[31 -: MW] ^ {1'b1, {(MW-1){1'b0}}};
            default:                 int_wave = '0;
        endcase
    end

    // modulating sample: settings only for internal; external and channel take their signal
    logic signed [MW-1:0] mod_wave;
    always_comb
    begin
        case (src)
            bkpwm_pkg::SRC_INT:  mod_wave = int_wave;   // RULE_13
            bkpwm_pkg::SRC_EXT:  mod_wave = ext_mod;    // RULE_12 RULE_11
            bkpwm_pkg::SRC_CHAN: mod_wave = modulating_channel_en ? modulating_channel_wave
                                                                  : '0;   // RULE_09 RULE_10
            default:             mod_wave = '0;
        endcase
    end

    // pwm width: nominal plus deviation scaled by normalised sample, full scale hits full dev
    logic signed [MW+16:0] dev_prod;
    logic signed [17:0]    width_mod;
    assign dev_prod  = mod_wave * $signed({1'b0, wdev});   // RULE_02 RULE_03
    // dropping MW-1 low bits divides by the sample's full-scale magnitude, so a full swing
    // moves the width by exactly wdev; an extra halving here would give only half the deviation
    assign width_mod = $signed({2'b00, width}) + $signed(dev_prod[MW+16 -: 18]);   // RULE_03
    assign pwm_ok    = is_pulse;   // RULE_01

    // carrier controls; ask, fsk and psk changes line up with the registered keying bit, pwm width follows width_mod
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            carrier_channel_inc   <= 32'h0000_0000;
            carrier_channel_phase <= 32'h0000_0000;
            carrier_channel_on    <= 1'b0;
            carrier_channel_width <= 16'h0000;
            pwm_refused           <= 1'b0;
        end
        else
        begin
            carrier_channel_inc   <= car_inc;
            carrier_channel_on    <= 1'b1;
            carrier_channel_width <= width;
            pwm_refused           <= en && mtype == bkpwm_pkg::TYPE_PWM && !is_pulse;   // RULE_01
            if (en)
            begin
                case (mtype)
                    bkpwm_pkg::TYPE_PWM:
                        if (is_pulse)   // RULE_01
                        begin
                            if (width_mod < 0)
                                carrier_channel_width <= 16'h0000;
                            else if (width_mod > 18'sh0FFFF)
                                carrier_channel_width <= 16'hFFFF;
                            else
                                carrier_channel_width <= width_mod[15:0];   // RULE_02
                        end
                    bkpwm_pkg::TYPE_ASK:
                        carrier_channel_on <= key_bit;   // RULE_04 RULE_14
                    bkpwm_pkg::TYPE_FSK:
                        carrier_channel_inc <= key_bit ? hop_inc : car_inc;   // RULE_07
                    bkpwm_pkg::TYPE_PSK:
                        if (key_bit != key_prev)   // RULE_14
                            carrier_channel_phase <= (key_bit ^ pol_inv)
                                ? 32'h0000_0000 : bkpwm_pkg::PHASE_HALF;   // RULE_08
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/bkpwm_far_model.sv]
// far-side model: external modulation and trigger source plus the other channel
`timescale 1ns/1ps
`default_nettype none
module bkpwm_far_model #(
    parameter int MW = 16
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          trig_req,
    input  wire logic [MW-1:0] wave_req,
    input  wire logic          en_req,
    output var  logic          ext_trig,
    output var  logic [MW-1:0] ext_mod,
    output var  logic [MW-1:0] wave,
    output var  logic          wave_en
);
    // sources change just after the edge, like a sampled generator output
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_trig <= 1'b0;
            ext_mod  <= '0;
            wave     <= '0;
            wave_en  <= 1'b0;
        end
        else
        begin
            ext_trig <= trig_req;
            ext_mod  <= wave_req;
            wave_en  <= en_req;
            // a disabled channel inverts its word every cycle, so a zero word alternates with all ones
            wave     <= en_req ? wave_req : ~wave;
        end
    end
endmodule
`default_nettype wire

// [testbench/bkpwm_monitor.sv]
// assertion checker for the keying and pwm modulator, top ports only
`timescale 1ns/1ps
`default_nettype none
module bkpwm_monitor #(
    parameter int MW = 16
) (
    input wire logic          clk,
    input wire logic          nrst,
    input wire logic [7:0]    addr,
    input wire logic [31:0]   wdata,
    input wire logic          wr,
    input wire logic          ext_trig,
    input wire logic [MW-1:0] modulating_channel_wave,
    input wire logic          modulating_channel_en,
    input wire logic [31:0]   carrier_channel_inc,
    input wire logic [31:0]   carrier_channel_phase,
    input wire logic          carrier_channel_on,
    input wire logic          pwm_refused
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [31:0] ctrl;  // shadow of the control word
    logic [31:0] car;   // shadow of the carrier increment
    logic [31:0] hop;   // shadow of the hop increment
    logic [2:0]  ty;    // active type, off while disabled
    logic [1:0]  sr;    // selected source
    // shadows follow the very writes the block takes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl <= '0;
            car  <= '0;
            hop  <= '0;
        end
        else if (wr)
        begin
            if (addr == bkpwm_pkg::REG_CTRL) ctrl <= wdata;
            if (addr == bkpwm_pkg::REG_CAR_INC) car <= wdata;
            if (addr == bkpwm_pkg::REG_HOP_INC) hop <= wdata;
        end
    end
    assign ty = ctrl[0] ? ctrl[3:1] : bkpwm_pkg::TYPE_OFF;
    assign sr = ctrl[5:4];
    logic ask_ext, fsk_ext, ask_chan, psk_ext, want_ref;
    assign ask_ext  = ty == bkpwm_pkg::TYPE_ASK && sr == bkpwm_pkg::SRC_EXT;
    assign fsk_ext  = ty == bkpwm_pkg::TYPE_FSK && sr == bkpwm_pkg::SRC_EXT;
    assign ask_chan = ty == bkpwm_pkg::TYPE_ASK && sr == bkpwm_pkg::SRC_CHAN;
    assign psk_ext  = ty == bkpwm_pkg::TYPE_PSK && sr == bkpwm_pkg::SRC_EXT;
    // refusal is judged only once the setting has settled for two edges
    assign want_ref = ty == bkpwm_pkg::TYPE_PWM && !ctrl[9];
    AST_REFUSE: assert property (want_ref == $past(want_ref) && want_ref == $past(want_ref, 2)
        |-> pwm_refused == want_ref) else $error("pwm refusal wrong");
    AST_ASK_ON: assert property ((ask_ext && ext_trig)[*8] |-> carrier_channel_on)
        else $error("ask carrier not on");
    AST_ASK_OFF: assert property ((ask_ext && !ext_trig)[*8] |-> !carrier_channel_on)
        else $error("ask carrier not off");
    AST_FSK_HOP: assert property ((fsk_ext && ext_trig)[*8] |-> carrier_channel_inc == hop)
        else $error("fsk hop increment wrong");
    AST_FSK_CAR: assert property ((fsk_ext && !ext_trig)[*8] |-> carrier_channel_inc == car)
        else $error("fsk carrier increment wrong");
    AST_CHAN_OFF: assert property ((ask_chan && !modulating_channel_en)[*4]
        |-> !carrier_channel_on) else $error("disabled channel still keys");
    AST_CHAN_ON: assert property ((ask_chan && modulating_channel_en
        && !modulating_channel_wave[MW-1])[*4] |-> carrier_channel_on) else $error("channel key lost");
    AST_PHASE_SET: assert property (carrier_channel_phase == 32'h0
        || carrier_channel_phase == bkpwm_pkg::PHASE_HALF) else $error("phase off grid");
    // a settled low then a settled high level must leave the rise phase of the polarity
    AST_PSK_RISE: assert property ((psk_ext && !ext_trig)[*8] ##1 (psk_ext && ext_trig)[*8]
        |-> carrier_channel_phase == (ctrl[8] ? bkpwm_pkg::PHASE_HALF : 32'h0))
        else $error("psk phase after rise wrong");
    cover property (ask_ext && carrier_channel_on);
    cover property (fsk_ext && carrier_channel_inc == hop);
    cover property (pwm_refused);
endmodule
bind bkpwm_top bkpwm_monitor #(.MW(MW)) u_mon (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .ext_trig(ext_trig), .modulating_channel_wave(modulating_channel_wave),
    .modulating_channel_en(modulating_channel_en), .carrier_channel_inc(carrier_channel_inc),
    .carrier_channel_phase(carrier_channel_phase), .carrier_channel_on(carrier_channel_on),
    .pwm_refused(pwm_refused));
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the keying and pwm modulator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, nrst, wr, rd, trig_req, en_req, trig, on, ref_f, m_en;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, inc, phase;
    logic [15:0] wave_req, emod, wave, width;
    int          mismatches, tests_run, cycles;
    bkpwm_top #(.MW(16)) DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ext_trig(trig), .ext_mod(emod), .modulating_channel_wave(wave),
        .modulating_channel_en(m_en), .carrier_channel_inc(inc), .carrier_channel_phase(phase),
        .carrier_channel_on(on), .carrier_channel_width(width), .pwm_refused(ref_f));
    bkpwm_far_model #(.MW(16)) u_far (.clk(clk), .nrst(nrst), .trig_req(trig_req),
        .wave_req(wave_req), .en_req(en_req), .ext_trig(trig), .ext_mod(emod), .wave(wave),
        .wave_en(m_en));
    always #2.5 clk = ~clk;
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle right after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // far side levels, then time for the trigger synchroniser to settle
    task automatic far(input logic t, input logic [15:0] w, input logic e);
        @(posedge clk);
        trig_req <= t;
        wave_req <= w;
        en_req <= e;
        tick(10);
    endtask
    function automatic logic [31:0] mk(input logic [2:0] t, input logic [1:0] s,
        input logic pol, input logic pulse);
        return {22'h0, pulse, pol, 2'h0, s, t, 1'b1};
    endfunction
    task automatic t_regs;
        logic [31:0] v;
        rd_reg(bkpwm_pkg::REG_WIDTH, v);
        check("width_rst", v, {16'h0, bkpwm_pkg::WIDTH_RST});
        rd_reg(bkpwm_pkg::REG_KEY_INC, v);
        check("key_rst", v, bkpwm_pkg::INC_RST);
        wr_reg(bkpwm_pkg::REG_CTRL, 32'hFFFFFFFF);
        rd_reg(bkpwm_pkg::REG_CTRL, v);
        check("ctrl_mask", v, 32'h000003FF);
        wr_reg(8'h40, 32'h12345678);
        rd_reg(8'h40, v);
        check("unmapped", v, 32'h0);
    endtask
    task automatic t_keyed;
        logic [31:0] v;
        wr_reg(bkpwm_pkg::REG_CAR_INC, 32'h11110000);
        wr_reg(bkpwm_pkg::REG_HOP_INC, 32'h22220000);
        wr_reg(bkpwm_pkg::REG_CTRL, mk(bkpwm_pkg::TYPE_ASK, bkpwm_pkg::SRC_EXT, 0, 0));
        far(1, 0, 0);
        check("ask_on", {31'h0, on}, 1);
        // status: enable, key bit, carrier on and synchronised trigger high, no pulse flag
        rd_reg(bkpwm_pkg::REG_STATUS, v);
        check("status", v, 32'h00000017);
        far(0, 0, 0);
        check("ask_off", {31'h0, on}, 0);
        wr_reg(bkpwm_pkg::REG_CTRL, mk(bkpwm_pkg::TYPE_FSK, bkpwm_pkg::SRC_EXT, 0, 0));
        far(1, 0, 0);
        check("fsk_hop", inc, 32'h22220000);
        far(0, 0, 0);
        check("fsk_car", inc, 32'h11110000);
        wr_reg(bkpwm_pkg::REG_CTRL, mk(bkpwm_pkg::TYPE_PSK, bkpwm_pkg::SRC_EXT, 0, 0));
        far(1, 0, 0);
        check("psk_rise", phase, 32'h0);
        far(0, 0, 0);
        check("psk_fall", phase, bkpwm_pkg::PHASE_HALF);
        wr_reg(bkpwm_pkg::REG_CTRL, mk(bkpwm_pkg::TYPE_PSK, bkpwm_pkg::SRC_EXT, 1, 0));
        far(1, 0, 0);
        check("psk_inv_rise", phase, bkpwm_pkg::PHASE_HALF);
        far(0, 0, 0);
        check("psk_inv_fall", phase, 32'h0);
    endtask
    task automatic t_rate;
        logic last;
        int n;
        // 2 x 0x08000000 per cycle wraps every 16 cycles
        wr_reg(bkpwm_pkg::REG_KEY_INC, 32'h08000000);
        wr_reg(bkpwm_pkg::REG_CTRL, mk(bkpwm_pkg::TYPE_ASK, bkpwm_pkg::SRC_INT, 0, 0));
        // the first two gaps start from the mode switch, not from a keying edge
        for (int k = 0; k < 4; k++)
        begin
            last = on;
            n = 0;
            do
            begin
                tick(1);
                n++;
            end while (on === last && n < 40);
            if (k > 1) check("key_period", n, 16);
        end
    endtask
    task automatic t_chan;
        wr_reg(bkpwm_pkg::REG_CTRL, mk(bkpwm_pkg::TYPE_ASK, bkpwm_pkg::SRC_CHAN, 0, 0));
        // negative first; the gate is already shut after the switch, so only the positive and disable checks see it actually move
        far(0, 16'hF000, 1);
        check("chan_neg", {31'h0, on}, 0);
        far(0, 16'h1000, 1);
        check("chan_pos", {31'h0, on}, 1);
        far(0, 16'h1000, 0);
        check("chan_dis", {31'h0, on}, 0);
    endtask
    task automatic t_pwm;
        wr_reg(bkpwm_pkg::REG_WIDTH, 32'h00004000);
        wr_reg(bkpwm_pkg::REG_WDEV, 32'h00001000);
        wr_reg(bkpwm_pkg::REG_MOD_INC, 32'h01000000);
        wr_reg(bkpwm_pkg::REG_CTRL, mk(bkpwm_pkg::TYPE_PWM, bkpwm_pkg::SRC_EXT, 0, 0));
        far(0, 16'h0000, 0);
        check("pwm_refused", {31'h0, ref_f}, 1);
        // own shape and rate are set but must not move the width
        wr_reg(bkpwm_pkg::REG_CTRL, mk(bkpwm_pkg::TYPE_PWM, bkpwm_pkg::SRC_EXT, 0, 1) | 32'h40);
        tick(30);
        check("pwm_allowed", {31'h0, ref_f}, 0);
        check("width_mid", {16'h0, width}, 32'h4000);
        far(0, 16'h7FFF, 0);
        // 0x7FFF of 0x8000 full scale times deviation 0x1000 adds 0x0FFF
        check("width_hi", {16'h0, width}, 32'h00004FFF);
        far(0, 16'h8000, 0);
        check("width_lo", {16'h0, width}, 32'h00003000);
    endtask
    initial
    begin
        {clk, nrst, wr, rd, trig_req, en_req} = '0;
        addr = '0;
        wdata = '0;
        wave_req = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_keyed();
        t_rate();
        t_chan();
        t_pwm();
        complete_run();
    end
endmodule
`default_nettype wire
